// ### hw/lpm_pkg.sv
// Shared constants and types for the low-power mode controller
package lpm_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] ADDR_LOOP_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CONFIG    = 8'h04;
    localparam logic [7:0] ADDR_LOOP_SET  = 8'h08;
    localparam logic [7:0] ADDR_BRK_ADDR  = 8'h0c;
    localparam logic [7:0] ADDR_WDOG      = 8'h10;
    localparam logic [7:0] ADDR_STATUS    = 8'h14;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BIT_BCS      = 0;  // loop_control_register
    localparam int BIT_LOOP_PWR = 1;  // loop_control_register
    localparam int BIT_OSC_RUN  = 0;  // config
    localparam int BIT_BRK_EN   = 1;  // config
    localparam int ST_MODE_LSB  = 0;  // status, 4 bits
    localparam int ST_MASK      = 4;
    localparam int ST_CPU_CLK   = 5;
    localparam int ST_OSC       = 6;
    localparam int ST_LOOP      = 7;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [1:0] RST_LOOP_CTRL = 2'h0;
    localparam logic [1:0] RST_CONFIG    = 2'h0;
    localparam logic       RST_INT_MASK  = 1'h1;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int OSC_STAB_NS   = 32000;
    localparam int STAB_CYCLES   =
        (OSC_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WDOG_TIMEOUT_CYCLES = 262144;

    // ****************************************************************
    // Power modes, one-hot
    // ****************************************************************
    typedef enum logic [3:0] {
        MODE_RUN  = 4'h1,
        MODE_WAIT = 4'h2,
        MODE_STOP = 4'h4,
        MODE_STAB = 4'h8
    } power_mode_t;

endpackage

// ### hw/low_power_mode_control.sv
// Low-power mode controller: wait/stop sequencing, clocks, watchdog
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ns

module low_power_mode_control #(
    parameter int BRK_W        = 16,
    parameter int LOOP_SET_W   = 8,
    parameter int WDOG_TIMEOUT = lpm_pkg::WDOG_TIMEOUT_CYCLES,
    parameter int STAB_COUNT   = lpm_pkg::STAB_CYCLES
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Processor core
    input  wire logic              wait_exec,
    input  wire logic              stop_exec,
    input  wire logic              irq_pending,
    input  wire logic              ext_irq,
    input  wire logic              cpu_mask_set,
    input  wire logic              cpu_mask_clear,
    input  wire logic [BRK_W-1:0]  cpu_addr,
    input  wire logic              cpu_addr_valid,
    output logic                   int_mask,
    output logic                   cpu_clock_en,
    output logic                   resume,
    output logic                   break_request,
    // Clock generator controls
    output logic                   osc_enable,
    output logic                   loop_enable,
    output logic                   bus_clock_from_loop,
    output logic                   crystal_clock_en,
    output logic                   bus_clock_en,
    output logic                   gen_int_en,
    output logic [LOOP_SET_W-1:0]  loop_settings,
    // Watchdog
    output logic                   watchdog_reset
);

    localparam int WDOG_W = $clog2(WDOG_TIMEOUT + 1);
    localparam int STAB_W = $clog2(STAB_COUNT + 1);
    localparam logic [WDOG_W-1:0] WDOG_LAST = WDOG_W'(WDOG_TIMEOUT - 1);
    localparam logic [STAB_W-1:0] STAB_LAST = STAB_W'(STAB_COUNT - 1);

    // ****************************************************************
    // APB slave and register file
    // ****************************************************************
    logic                   setup;
    logic                   wr;
    logic                   mapped;
    logic [1:0]             loop_control_register;
    logic [1:0]             config_reg;
    logic [BRK_W-1:0]       brk_addr;
    logic                   wdog_clear;
    logic [1:0]             next_loop_ctrl;
    logic [1:0]             next_config;
    logic [LOOP_SET_W-1:0]  next_loop_set;
    logic [BRK_W-1:0]       next_brk_addr;
    logic [31:0]            next_prdata;
    logic                   next_pready;
    logic                   next_pslverr;
    logic [7:0]             status;
    lpm_pkg::power_mode_t   mode;
    lpm_pkg::power_mode_t   next_mode;
    logic [WDOG_W-1:0]      wdog_cnt;
    logic [STAB_W-1:0]      stab_cnt;

    assign setup = psel & ~penable;
    assign wr    = psel & penable & pready & pwrite;

    // Decode and next register values; zero wait states
    always_comb begin
        next_loop_ctrl = loop_control_register;
        next_config    = config_reg;
        next_loop_set  = loop_settings;
        next_brk_addr  = brk_addr;
        wdog_clear     = 1'b0;
        mapped         = 1'b1;
        next_prdata    = 32'h0;
        if (paddr == lpm_pkg::ADDR_LOOP_CTRL) begin
            next_prdata = 32'(loop_control_register);
            if (wr) begin
                next_loop_ctrl = pwdata[1:0];
            end
        end else if (paddr == lpm_pkg::ADDR_CONFIG) begin
            next_prdata = 32'(config_reg);
            if (wr) begin
                next_config = pwdata[1:0];
            end
        end else if (paddr == lpm_pkg::ADDR_LOOP_SET) begin
            next_prdata = 32'(loop_settings);
            // Writes while the loop is powered are dropped
            if (wr && !loop_control_register[lpm_pkg::BIT_LOOP_PWR]) begin
                next_loop_set = pwdata[LOOP_SET_W-1:0];
            end
        end else if (paddr == lpm_pkg::ADDR_BRK_ADDR) begin
            next_prdata = 32'(brk_addr);
            if (wr) begin
                next_brk_addr = pwdata[BRK_W-1:0];
            end
        end else if (paddr == lpm_pkg::ADDR_WDOG) begin
            next_prdata = 32'(wdog_cnt);
            wdog_clear  = wr;
        end else if (paddr == lpm_pkg::ADDR_STATUS) begin
            next_prdata = 32'(status);
        end else begin
            mapped = 1'b0;
        end
        next_pready  = setup;
        next_pslverr = setup & ~mapped;
        if (!setup) begin
            next_prdata = prdata;
        end
    end

    // Registers; stop entry never touches the break match word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_control_register <= lpm_pkg::RST_LOOP_CTRL;
            config_reg            <= lpm_pkg::RST_CONFIG;
            loop_settings         <= '0;
            brk_addr              <= '0;
            prdata                <= 32'h0;
            pready                <= 1'b0;
            pslverr               <= 1'b0;
        end else begin
            loop_control_register <= next_loop_ctrl;
            config_reg            <= next_config;
            loop_settings         <= next_loop_set;
            brk_addr              <= next_brk_addr;
            prdata                <= next_prdata;
            pready                <= next_pready;
            pslverr               <= next_pslverr;
        end
    end

    assign status = {loop_enable, osc_enable, cpu_clock_en, int_mask,
                     mode};

    // ****************************************************************
    // Mode sequencer
    // ****************************************************************
    logic [STAB_W-1:0]      next_stab_cnt;
    logic                   next_int_mask;
    logic                   entering;

    assign entering = (mode == lpm_pkg::MODE_RUN) & (wait_exec | stop_exec);

    // Stop takes priority if the core flags both at once
    always_comb begin
        next_mode     = mode;
        next_stab_cnt = stab_cnt;
        case (mode)
            lpm_pkg::MODE_RUN: begin
                if (stop_exec) begin
                    next_mode = lpm_pkg::MODE_STOP;
                end else if (wait_exec) begin
                    next_mode = lpm_pkg::MODE_WAIT;
                end
            end
            lpm_pkg::MODE_WAIT: begin
                if (irq_pending) begin
                    next_mode = lpm_pkg::MODE_RUN;
                end
            end
            lpm_pkg::MODE_STOP: begin
                if (ext_irq) begin
                    next_mode     = lpm_pkg::MODE_STAB;
                    next_stab_cnt = STAB_LAST;
                end
            end
            lpm_pkg::MODE_STAB: begin
                // Oscillator settling before the core restarts
                if (stab_cnt == '0) begin
                    next_mode = lpm_pkg::MODE_RUN;
                end else begin
                    next_stab_cnt = stab_cnt - STAB_W'(1);
                end
            end
            default: begin
                next_mode = lpm_pkg::MODE_RUN;
            end
        endcase
        // Interrupt exits leave the mask as it is
        next_int_mask = int_mask;
        if (cpu_mask_set) begin
            next_int_mask = 1'b1;
        end else if (cpu_mask_clear) begin
            next_int_mask = 1'b0;
        end
        if (entering) begin
            next_int_mask = 1'b0;
        end
    end

    // Reset always lands in run with the mask set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode     <= lpm_pkg::MODE_RUN;
            stab_cnt <= '0;
            int_mask <= lpm_pkg::RST_INT_MASK;
        end else begin
            mode     <= next_mode;
            stab_cnt <= next_stab_cnt;
            int_mask <= next_int_mask;
        end
    end

    // ****************************************************************
    // Clock generator, break and watchdog outputs
    // ****************************************************************
    logic                   nstop;
    logic                   n_osc;
    logic                   n_loop;
    logic                   n_brk;
    logic                   n_fire;
    logic [WDOG_W-1:0]      next_wdog_cnt;

    // Clock outputs follow the next mode so they line up with it; break and watchdog use the current mode
    always_comb begin
        nstop  = next_mode != lpm_pkg::MODE_STOP;
        n_osc  = nstop | next_config[lpm_pkg::BIT_OSC_RUN];
        n_loop = nstop & next_loop_ctrl[lpm_pkg::BIT_LOOP_PWR];
        n_brk  = config_reg[lpm_pkg::BIT_BRK_EN] & cpu_addr_valid &
                 (cpu_addr == brk_addr) &
                 (mode != lpm_pkg::MODE_STOP);
        // Watchdog runs off the bus clock, so it rests in stop
        n_fire = (mode != lpm_pkg::MODE_STOP) && (wdog_cnt == WDOG_LAST);
        next_wdog_cnt = wdog_cnt;
        if (wdog_clear || n_fire) begin
            next_wdog_cnt = '0;
        end else if (mode != lpm_pkg::MODE_STOP) begin
            next_wdog_cnt = wdog_cnt + WDOG_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_clock_en        <= 1'b1;
            resume              <= 1'b0;
            osc_enable          <= 1'b1;
            loop_enable         <= 1'b0;
            bus_clock_from_loop <= 1'b0;
            crystal_clock_en    <= 1'b1;
            bus_clock_en        <= 1'b1;
            gen_int_en          <= 1'b1;
            break_request       <= 1'b0;
            wdog_cnt            <= '0;
            watchdog_reset      <= 1'b0;
        end else begin
            cpu_clock_en        <= next_mode == lpm_pkg::MODE_RUN;
            resume              <= (next_mode == lpm_pkg::MODE_RUN) &&
                                   (mode != lpm_pkg::MODE_RUN);
            osc_enable          <= n_osc;
            loop_enable         <= n_loop;
            // Deselect without power-down keeps the loop warm
            bus_clock_from_loop <= n_loop &
                                   next_loop_ctrl[lpm_pkg::BIT_BCS];
            crystal_clock_en    <= n_osc;
            bus_clock_en        <= nstop;
            gen_int_en          <= nstop;
            break_request       <= n_brk;
            wdog_cnt            <= next_wdog_cnt;
            watchdog_reset      <= n_fire;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_break_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        mode == lpm_pkg::MODE_STOP |=> !break_request)
        else $error("break raised in stop");
    a_brk_kept: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(mode == lpm_pkg::MODE_STOP) |->
        brk_addr == $past(brk_addr))
        else $error("break register changed on stop");
    a_wait_entry: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == lpm_pkg::MODE_RUN && wait_exec && !stop_exec) |=>
        (!int_mask && !cpu_clock_en && mode == lpm_pkg::MODE_WAIT))
        else $error("wait entry wrong");
    a_stop_entry: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == lpm_pkg::MODE_RUN && stop_exec) |=>
        (!int_mask && !cpu_clock_en && mode == lpm_pkg::MODE_STOP))
        else $error("stop entry wrong");
    a_stab_hold: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(mode) == lpm_pkg::MODE_STAB && mode == lpm_pkg::MODE_RUN)
        |-> ($past(stab_cnt) == '0 && cpu_clock_en &&
             !$past(cpu_clock_en)))
        else $error("clock restarted early");
    a_stab_clkoff: assert property (@(posedge pclk) disable iff (!presetn)
        mode == lpm_pkg::MODE_STAB |-> !cpu_clock_en &&
        crystal_clock_en)
        else $error("cpu clock on while settling");
    a_gen_wait: assert property (@(posedge pclk) disable iff (!presetn)
        mode == lpm_pkg::MODE_WAIT |-> osc_enable && crystal_clock_en &&
        bus_clock_en && loop_enable ==
        loop_control_register[lpm_pkg::BIT_LOOP_PWR])
        else $error("generator off in wait");
    a_stop_dflt: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == lpm_pkg::MODE_STOP && !config_reg[lpm_pkg::BIT_OSC_RUN])
        |-> !(osc_enable | loop_enable | crystal_clock_en | bus_clock_en |
              gen_int_en))
        else $error("generator alive in stop");
    a_stop_osc: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == lpm_pkg::MODE_STOP && config_reg[lpm_pkg::BIT_OSC_RUN])
        |-> osc_enable && !loop_enable)
        else $error("run-in-stop wrong");
    a_loop_desel: assert property (@(posedge pclk) disable iff (!presetn)
        (mode != lpm_pkg::MODE_STOP &&
         loop_control_register == 2'h2) |->
        loop_enable && !bus_clock_from_loop)
        else $error("deselected loop not running");
    a_wdog_fire: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == lpm_pkg::MODE_WAIT && wdog_cnt == WDOG_LAST) |=>
        watchdog_reset && wdog_cnt == '0)
        else $error("watchdog did not fire");
    a_wake_resume: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == lpm_pkg::MODE_WAIT && irq_pending) |=>
        (resume && cpu_clock_en && mode == lpm_pkg::MODE_RUN) ##1
        !resume)
        else $error("wait wake wrong");

endmodule

// ### bench/core_model.sv
// Processor core model: instructions, interrupts and fetches
`timescale 1ns/1ns
module core_model (
    // Clock and gate from the controller
    input  wire logic        pclk,
    input  wire logic        cpu_clock_en,
    // Core requests
    output logic             wait_exec,
    output logic             stop_exec,
    output logic             irq_pending,
    output logic             ext_irq,
    output logic             cpu_mask_set,
    output logic             cpu_mask_clear,
    output logic [15:0]      cpu_addr,
    output logic             cpu_addr_valid
);
    // Quiet core at time zero
    initial begin
        {wait_exec, stop_exec, irq_pending, ext_irq} = 4'h0;
        {cpu_mask_set, cpu_mask_clear, cpu_addr_valid} = 3'h0;
        cpu_addr = 16'h5a5a;
    end

    // A gated core cannot execute, so no pulse without a clock
    task automatic exec(input bit stop);
        @(posedge pclk);
        if (cpu_clock_en === 1'b1) begin
            wait_exec <= !stop;
            stop_exec <= stop;
        end
        @(posedge pclk);
        wait_exec <= 1'b0;
        stop_exec <= 1'b0;
    endtask

    // Interrupt level held for n edges
    task automatic irq(input bit ext, input int n);
        @(posedge pclk);
        if (ext) ext_irq <= 1'b1;
        else irq_pending <= 1'b1;
        repeat (n) @(posedge pclk);
        ext_irq <= 1'b0;
        irq_pending <= 1'b0;
    endtask

    // Own mask instruction, one pulse
    task automatic mask(input bit set);
        @(posedge pclk);
        cpu_mask_set <= set;
        cpu_mask_clear <= !set;
        @(posedge pclk);
        {cpu_mask_set, cpu_mask_clear} <= 2'h0;
    endtask

    // One fetch; afterwards the bus shows junk, not the old address
    task automatic fetch(input logic [15:0] a);
        @(posedge pclk);
        cpu_addr <= a;
        cpu_addr_valid <= 1'b1;
        @(posedge pclk);
        cpu_addr <= ~a;
        cpu_addr_valid <= 1'b0;
    endtask
endmodule

// ### bench/low_power_mode_control_tb.sv
// Self-checking bench for the low-power mode controller
`timescale 1ns/1ns
module low_power_mode_control_tb;
    localparam int WD = 64;
    localparam int ST = 8;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h8d63;
    logic        pready, pslverr, we, wr_, st_e, lp_e;
    logic        int_mask, cpu_clock_en, resume, break_request;
    logic        osc_enable, loop_enable, bus_clock_from_loop;
    logic        crystal_clock_en, bus_clock_en, gen_int_en;
    logic        watchdog_reset, irq_p, ext_i, m_set, m_clr, a_val;
    logic [15:0] cpu_addr;
    logic [7:0]  loop_settings;
    int          miscompares = 0, n_tests = 0, cycles = 0, k;
    int          m_set_val = 0, m_brk;

    always #4 pclk = ~pclk;

    low_power_mode_control #(.WDOG_TIMEOUT(WD), .STAB_COUNT(ST))
    i_low_power_mode_control (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wait_exec(we),
        .stop_exec(wr_), .irq_pending(irq_p), .ext_irq(ext_i),
        .cpu_mask_set(m_set), .cpu_mask_clear(m_clr),
        .cpu_addr(cpu_addr), .cpu_addr_valid(a_val),
        .int_mask(int_mask), .cpu_clock_en(cpu_clock_en),
        .resume(resume), .break_request(break_request),
        .osc_enable(osc_enable), .loop_enable(loop_enable),
        .bus_clock_from_loop(bus_clock_from_loop),
        .crystal_clock_en(crystal_clock_en), .bus_clock_en(bus_clock_en),
        .gen_int_en(gen_int_en), .loop_settings(loop_settings),
        .watchdog_reset(watchdog_reset));

    core_model i_core_model (
        .pclk(pclk), .cpu_clock_en(cpu_clock_en), .wait_exec(we),
        .stop_exec(wr_), .irq_pending(irq_p), .ext_irq(ext_i),
        .cpu_mask_set(m_set), .cpu_mask_clear(m_clr),
        .cpu_addr(cpu_addr), .cpu_addr_valid(a_val));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic give_verdict();
        $display("Counts: %0d compares, %0d mismatches", n_tests,
                 miscompares);
        if (miscompares == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected status word from the model's mode and gates
    function automatic logic [31:0] stw(int md, int mk, int ck, int os,
                                        int lp);
        return {24'h0, lp[0], os[0], ck[0], mk[0], md[3:0]};
    endfunction

    // One APB transfer; waits for pready with no bound of its own, only the hang guard
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk(e, 0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
        chk(e, xe);
    endtask

    // Edges from stop wake until the processor clock returns
    task automatic settle();
        k = 0;
        #1;
        while (cpu_clock_en !== 1'b1 && k < 100) begin
            @(posedge pclk);
            #1;
            k++;
        end
    endtask

    // Hang guard: the whole sequence needs well under this
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(lpm_pkg::ADDR_STATUS, stw(1, 1, 1, 1, 0), 1'b0);
        rd(lpm_pkg::ADDR_CONFIG, 32'h0, 1'b0);
        rd(8'h3c, 32'h0, 1'b1);
        $display("reset test done");
        // Deselect the loop but keep it running before wait
        wr(lpm_pkg::ADDR_LOOP_CTRL, 32'h3);
        #1;
        chk(bus_clock_from_loop, 1);
        wr(lpm_pkg::ADDR_LOOP_CTRL, 32'h2);
        #1;
        chk({bus_clock_from_loop, loop_enable}, 2'b01);
        seed = lfsr(seed);
        wr(lpm_pkg::ADDR_LOOP_SET, seed);
        rd(lpm_pkg::ADDR_LOOP_SET, m_set_val, 1'b0);
        i_core_model.exec(1'b0);
        #1;
        chk({int_mask, cpu_clock_en}, 2'b00);
        chk({osc_enable, loop_enable, crystal_clock_en, bus_clock_en,
             gen_int_en}, 5'h1f);
        rd(lpm_pkg::ADDR_STATUS, stw(2, 0, 0, 1, 1), 1'b0);
        i_core_model.irq(1'b0, 1);
        #1;
        chk({cpu_clock_en, resume, int_mask}, 3'b110);
        $display("wait test done");
        // Loop settings accepted once the loop is off
        wr(lpm_pkg::ADDR_LOOP_CTRL, 32'h0);
        seed = lfsr(seed);
        m_set_val = seed[7:0];
        wr(lpm_pkg::ADDR_LOOP_SET, seed);
        rd(lpm_pkg::ADDR_LOOP_SET, m_set_val, 1'b0);
        chk(loop_settings, m_set_val);
        i_core_model.mask(1'b1);
        #1;
        chk(int_mask, 1);
        $display("loop settings test done");
        // Default stop with break armed on a random address
        seed = lfsr(seed);
        m_brk = seed[15:0];
        wr(lpm_pkg::ADDR_BRK_ADDR, m_brk);
        wr(lpm_pkg::ADDR_CONFIG, 32'h2);
        i_core_model.fetch(m_brk[15:0]);
        #1;
        chk(break_request, 1);
        i_core_model.exec(1'b1);
        #1;
        chk({int_mask, cpu_clock_en}, 2'b00);
        chk({osc_enable, loop_enable, crystal_clock_en, bus_clock_en,
             gen_int_en}, 5'h00);
        i_core_model.fetch(m_brk[15:0]);
        #1;
        chk(break_request, 0);
        i_core_model.irq(1'b0, 3);
        rd(lpm_pkg::ADDR_STATUS, stw(4, 0, 0, 0, 0), 1'b0);
        i_core_model.irq(1'b1, 1);
        settle();
        chk(k, ST);
        chk({resume, int_mask}, 2'b10);
        rd(lpm_pkg::ADDR_BRK_ADDR, m_brk, 1'b0);
        $display("default stop test done");
        // Stop with the oscillator kept running
        wr(lpm_pkg::ADDR_CONFIG, 32'h1);
        i_core_model.exec(1'b1);
        #1;
        chk({osc_enable, loop_enable, crystal_clock_en}, 3'b101);
        i_core_model.irq(1'b1, 1);
        settle();
        chk(k, ST);
        $display("oscillator run stop test done");
        // Watchdog keeps counting through wait
        wr(lpm_pkg::ADDR_WDOG, 32'h0);
        i_core_model.exec(1'b0);
        k = 0;
        while (watchdog_reset !== 1'b1 && k < 2 * WD) begin
            @(posedge pclk);
            #1;
            k++;
        end
        chk(k >= WD - 12 && k <= WD, 1);
        chk(cpu_clock_en, 0);
        $display("watchdog test done");
        // Leave wait through reset: mask comes back set
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk(int_mask, 1);
        rd(lpm_pkg::ADDR_STATUS, stw(1, 1, 1, 1, 0), 1'b0);
        $display("reset exit test done");
        give_verdict();
    end
endmodule
